/* File: sfcp_pkg.sv */
// Shared constants and types of the serial frame command processor
// Behaviour
// - Frame spans select low to next rise
// - Open: ready low, edge counter zeroed
// - Open: output word loaded into shifter
// - Open: command holding register reads zero
// - Capture edge: count, shift input into LSB
// - Launch edge: shifter MSB onto selected lanes
// - Close: lanes released, ready held low
// - Close: command decoded, writes take effect
// - Host waits ready or longest conversion
// - Exactly 32 edges: optimal, valid command
// - Under 32 edges: writes dropped, no-op
// - Short frames still give valid leading bits
// - Over 32 edges: last 32 bits decode
// - Write data captured on serial clock only
// - Address is zero bit plus byte address
// - Half-word commands ignore address LSB
// - Zero and undefined opcodes change nothing
// - Opcode 11000 clears marked pair bits
// - Opcode 11011 sets marked pair bits
// - Opcode 11001 returns pair next frame
// - Opcode 01001 returns one byte next frame
// - Write sub-field picks both, high, low byte
package sfcp_pkg;
    localparam int CLK_NS = 5;
    localparam int FRAME_BITS = 32;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
    localparam int OP_HI = 31;
    localparam int OP_LO = 27;
    localparam int SUB_HI = 26;
    localparam int SUB_LO = 25;
    localparam int ADR_TOP = 24;
    localparam int ADR_HI = 23;
    localparam int ADR_LO = 16;
    localparam int DAT_HI = 15;
    localparam int REG_AW = 8;
    localparam logic [4:0] OP_CLR = 5'h18;
    localparam logic [4:0] OP_RDH = 5'h19;
    localparam logic [4:0] OP_RDB = 5'h09;
    localparam logic [4:0] OP_WR = 5'h1a;
    localparam logic [4:0] OP_SET = 5'h1b;
    localparam logic [1:0] SUB_BOTH = 2'h0;
    localparam logic [1:0] SUB_HIGH = 2'h1;
    localparam logic [1:0] SUB_LOW = 2'h2;
    localparam logic [31:0] CMD_NOP = 32'h0000_0000;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [1:0] FK_NONE = 2'h0;
    localparam logic [1:0] FK_SHORT = 2'h1;
    localparam logic [1:0] FK_OPT = 2'h2;
    localparam logic [1:0] FK_LONG = 2'h3;
    localparam int SCLK_PERIOD_NS = 125;
    localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS / 2 + CLK_NS - 1) / CLK_NS;
    localparam int CONV_NS = 500;
    localparam int CONV_CYC = CONV_NS / CLK_NS;
    localparam int MAX_CONVERSION_TIME_NS = 1000;
    localparam int MAX_CONVERSION_TIME_CYC = MAX_CONVERSION_TIME_NS / CLK_NS;
    typedef enum logic [1:0] {RS_CONV, RS_HALF_WORD, RS_BYTE} sfcp_rsel_t;
endpackage

/* File: sfcp_link_if.sv */
// Serial link between host and device with lane resolution
`timescale 1ns/10ps
interface sfcp_link_if #(parameter int LANES = 2);
    logic sclk;
    logic convert_start_select;
    logic sdi;
    logic [LANES-1:0] lane_o;
    logic [LANES-1:0] lane_oe;
    logic ready_indicator;
    wire [LANES-1:0] serial_output_lanes;
    genvar g;
    for (g = 0; g < LANES; g++) begin : g_lane
        assign serial_output_lanes[g] = lane_oe[g] & lane_o[g];
    end
    modport dev (input sclk, input convert_start_select, input sdi,
        output lane_o, output lane_oe, output ready_indicator);
    modport host (output sclk, output convert_start_select, output sdi,
        input serial_output_lanes, input ready_indicator);
endinterface

/* File: sfcp_dev.sv */
// Device end: serial frame shifter and command processor
`timescale 1ns/10ps
module sfcp_dev
    import sfcp_pkg::*;
#(
    parameter int LANES = 2,
    parameter int CONV_CYCLES = CONV_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    sfcp_link_if.dev link,
    input wire logic [31:0] conv_word,
    input wire logic [LANES-1:0] lane_en,
    input wire logic [REG_AW-1:0] user_addr,
    output logic [7:0] user_rdata,
    output logic conv_start,
    output logic [1:0] frame_kind,
    output logic [31:0] last_cmd
);
    typedef enum logic [2:0] {ST_IDLE, ST_FRAME, ST_EXEC, ST_CLEAR, ST_CONV} sfcp_dst_t;

    sfcp_dst_t state_r;
    logic cs_m_r, cs_s_r, cs_d_r;
    logic clr_r;
    logic ready_r;
    logic [31:0] in_shift_r;
    logic [CNT_W-1:0] cap_cnt_r;
    logic [CNT_W-1:0] launch_cnt_r;
    logic [31:0] out_word_r;
    logic [31:0] rd_word_r;
    logic rd_pend_r;
    logic [15:0] conv_cnt_r;
    logic [7:0] regs_r [0:(1<<REG_AW)-1];
    logic cs_fall, cs_rise;
    logic [1:0] kind;
    logic cmd_ok;
    logic [4:0] op;
    logic [1:0] sub;
    logic [REG_AW-1:0] a_full, a_lo, a_hi;
    logic [7:0] d_hi, d_lo, n_hi, n_lo;
    logic wr_hi, wr_lo;
    sfcp_rsel_t rsel;
    logic lane_bit;
    logic chain_bit_r;

    // Link side: capture on rising serial clock edges only
    always_ff @(posedge link.sclk or posedge clr_r) begin
        if (clr_r) begin
            in_shift_r <= CMD_NOP;
            cap_cnt_r <= '0;
        end else begin
            in_shift_r <= {in_shift_r[30:0], link.sdi};
            if (cap_cnt_r != CNT_MAX) begin
                cap_cnt_r <= cap_cnt_r + 6'h01;
            end
        end
    end

    // Link side: step to next output bit on falling edges
    always_ff @(negedge link.sclk or posedge clr_r) begin
        if (clr_r) begin
            launch_cnt_r <= '0;
        end else if (launch_cnt_r != CNT_FULL) begin
            launch_cnt_r <= launch_cnt_r + 6'h01;
        end
    end

    // Link side: chained bit moves out on falling edges only
    always_ff @(negedge link.sclk or posedge clr_r) begin
        if (clr_r) begin
            chain_bit_r <= 1'b0;
        end else begin
            chain_bit_r <= in_shift_r[31];
        end
    end

    // Past 32 bits the received stream passes through, as in a chain
    assign lane_bit = (launch_cnt_r < CNT_FULL) ?
        out_word_r[5'h1f - launch_cnt_r[4:0]] : chain_bit_r;
    assign link.lane_o = {LANES{lane_bit}};
    assign link.lane_oe = link.convert_start_select ? '0 : lane_en;
    assign link.ready_indicator = ready_r & link.convert_start_select;

    // Select line synchroniser
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cs_m_r <= 1'b1;
            cs_s_r <= 1'b1;
            cs_d_r <= 1'b1;
        end else begin
            cs_m_r <= link.convert_start_select;
            cs_s_r <= cs_m_r;
            cs_d_r <= cs_s_r;
        end
    end
    assign cs_fall = cs_d_r & ~cs_s_r;
    assign cs_rise = ~cs_d_r & cs_s_r;

    // Frame classification from the capture count
    always_comb begin
        if (cap_cnt_r < CNT_FULL) begin
            kind = FK_SHORT;
        end else if (cap_cnt_r == CNT_FULL) begin
            kind = FK_OPT;
        end else begin
            kind = FK_LONG;
        end
    end

    // Command decode
    always_comb begin
        op = in_shift_r[OP_HI:OP_LO];
        sub = in_shift_r[SUB_HI:SUB_LO];
        a_full = in_shift_r[ADR_HI:ADR_LO];
        a_lo = {a_full[REG_AW-1:1], 1'b0};
        a_hi = {a_full[REG_AW-1:1], 1'b1};
        d_hi = in_shift_r[DAT_HI:8];
        d_lo = in_shift_r[7:0];
        cmd_ok = (kind != FK_SHORT) && !in_shift_r[ADR_TOP];
        n_hi = regs_r[a_hi];
        n_lo = regs_r[a_lo];
        wr_hi = 1'b0;
        wr_lo = 1'b0;
        rsel = RS_CONV;
        if (cmd_ok) begin
            if (op == OP_CLR) begin
                n_hi = regs_r[a_hi] & ~d_hi;
                n_lo = regs_r[a_lo] & ~d_lo;
                wr_hi = 1'b1;
                wr_lo = 1'b1;
            end else if (op == OP_SET) begin
                n_hi = regs_r[a_hi] | d_hi;
                n_lo = regs_r[a_lo] | d_lo;
                wr_hi = 1'b1;
                wr_lo = 1'b1;
            end else if (op == OP_WR) begin
                n_hi = d_hi;
                n_lo = d_lo;
                wr_hi = (sub == SUB_BOTH) || (sub == SUB_HIGH);
                wr_lo = (sub == SUB_BOTH) || (sub == SUB_LOW);
            end else if (op == OP_RDH) begin
                rsel = RS_HALF_WORD;
            end else if (op == OP_RDB) begin
                rsel = RS_BYTE;
            end
        end
    end

    // Frame and conversion sequencing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            clr_r <= 1'b1;
            ready_r <= 1'b1;
            conv_cnt_r <= '0;
            conv_start <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    clr_r <= 1'b0;
                    if (cs_fall) begin
                        ready_r <= 1'b0;
                        state_r <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (cs_rise) begin
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    conv_start <= 1'b1;
                    state_r <= ST_CLEAR;
                end
                ST_CLEAR: begin
                    clr_r <= 1'b1;
                    conv_cnt_r <= '0;
                    state_r <= ST_CONV;
                end
                ST_CONV: begin
                    clr_r <= 1'b0;
                    conv_cnt_r <= conv_cnt_r + 16'h0001;
                    if (conv_cnt_r == 16'(CONV_CYCLES - 1)) begin
                        ready_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Register pair writes at frame close
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < (1 << REG_AW); i++) begin
                regs_r[i] <= REG_RST;
            end
        end else if (state_r == ST_EXEC) begin
            if (wr_hi) begin
                regs_r[a_hi] <= n_hi;
            end
            if (wr_lo) begin
                regs_r[a_lo] <= n_lo;
            end
        end
    end

    // Read-back word for the next frame and frame report
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_word_r <= '0;
            rd_pend_r <= 1'b0;
            frame_kind <= FK_NONE;
            last_cmd <= CMD_NOP;
        end else if (state_r == ST_EXEC) begin
            frame_kind <= kind;
            last_cmd <= cmd_ok ? in_shift_r : CMD_NOP;
            rd_pend_r <= (rsel != RS_CONV);
            if (rsel == RS_HALF_WORD) begin
                rd_word_r <= {regs_r[a_hi], regs_r[a_lo], 16'h0000};
            end else begin
                rd_word_r <= {regs_r[a_full], 24'h00_0000};
            end
        end
    end

    // Output word loaded when a frame opens
    always_ff @(posedge core_clk) begin
        if (rst) begin
            out_word_r <= '0;
        end else if (state_r == ST_IDLE && cs_fall) begin
            out_word_r <= rd_pend_r ? rd_word_r : conv_word;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            user_rdata <= '0;
        end else begin
            user_rdata <= regs_r[user_addr];
        end
    end
endmodule

/* File: sfcp_host.sv */
// Host end: frame generator with divided serial clock
`timescale 1ns/10ps
module sfcp_host
    import sfcp_pkg::*;
#(
    parameter int HALF_CYCLES = SCLK_HALF_CYC,
    parameter int WAIT_CYCLES = MAX_CONVERSION_TIME_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    sfcp_link_if.host link,
    input wire logic req,
    input wire logic [31:0] req_cmd,
    input wire logic [CNT_W-1:0] req_bits,
    output logic busy,
    output logic rsp_valid,
    output logic [31:0] rsp_data
);
    typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_WAIT} sfcp_hst_t;

    sfcp_hst_t state_r;
    logic sclk_r, cs_r, sdi_r;
    logic sdo_m_r, sdo_s_r, rdy_m_r, rdy_s_r;
    logic [31:0] cmd_r;
    logic [CNT_W-1:0] nb_r, k_r;
    logic [15:0] tmr_r;

    // Bit k of a frame of nb bits; command sits last, leading zeros
    function automatic logic tx_bit(input logic [31:0] c, input logic [CNT_W-1:0] nb,
                                    input logic [CNT_W-1:0] k);
        logic [CNT_W-1:0] idx;
        idx = nb - k - 6'h01;
        tx_bit = (idx < CNT_FULL) ? c[idx[4:0]] : 1'b0;
    endfunction

    assign link.sclk = sclk_r;
    assign link.convert_start_select = cs_r;
    assign link.sdi = sdi_r;
    assign busy = (state_r != H_IDLE);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sdo_m_r <= 1'b0;
            sdo_s_r <= 1'b0;
            rdy_m_r <= 1'b0;
            rdy_s_r <= 1'b0;
        end else begin
            sdo_m_r <= link.serial_output_lanes[0];
            sdo_s_r <= sdo_m_r;
            rdy_m_r <= link.ready_indicator;
            rdy_s_r <= rdy_m_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= H_IDLE;
            sclk_r <= 1'b0;
            cs_r <= 1'b1;
            sdi_r <= 1'b0;
            cmd_r <= '0;
            nb_r <= '0;
            k_r <= '0;
            tmr_r <= '0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
        end else begin
            rsp_valid <= 1'b0;
            case (state_r)
                H_IDLE: begin
                    if (req && req_bits != '0) begin
                        cs_r <= 1'b0;
                        cmd_r <= req_cmd;
                        nb_r <= req_bits;
                        k_r <= '0;
                        sdi_r <= tx_bit(req_cmd, req_bits, 6'h00);
                        tmr_r <= '0;
                        state_r <= H_LOW;
                    end
                end
                H_LOW: begin
                    tmr_r <= tmr_r + 16'h0001;
                    if (tmr_r == 16'(HALF_CYCLES - 1)) begin
                        sclk_r <= 1'b1;
                        tmr_r <= '0;
                        state_r <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    tmr_r <= tmr_r + 16'h0001;
                    if (tmr_r == 16'(HALF_CYCLES - 1)) begin
                        rsp_data <= {rsp_data[30:0], sdo_s_r};
                        sclk_r <= 1'b0;
                        tmr_r <= '0;
                        k_r <= k_r + 6'h01;
                        sdi_r <= tx_bit(cmd_r, nb_r, k_r + 6'h01);
                        state_r <= (k_r == nb_r - 6'h01) ? H_TAIL : H_LOW;
                    end
                end
                H_TAIL: begin
                    tmr_r <= tmr_r + 16'h0001;
                    if (tmr_r == 16'(HALF_CYCLES - 1)) begin
                        cs_r <= 1'b1;
                        rsp_valid <= 1'b1;
                        tmr_r <= '0;
                        state_r <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    tmr_r <= tmr_r + 16'h0001;
                    if ((rdy_s_r && tmr_r > 16'h0003) ||
                        tmr_r == 16'(WAIT_CYCLES - 1)) begin
                        state_r <= H_IDLE;
                    end
                end
                default: begin
                    state_r <= H_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: sfcp_asserts.sv */
// Link protocol checker for the serial frame interface
`timescale 1ns/10ps
module sfcp_asserts #(
    parameter int LANES = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic convert_start_select,
    input wire logic sdi,
    input wire logic [LANES-1:0] lane_o,
    input wire logic [LANES-1:0] lane_oe,
    input wire logic ready_indicator
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_ready_low_frame: assert property (!convert_start_select |-> !ready_indicator)
        else $error("ready high inside frame");
    a_lanes_taken: assert property ($fell(convert_start_select) |-> ##[1:8] lane_oe != '0)
        else $error("lanes not driven after frame open");
    a_lanes_released: assert property (convert_start_select [*4] |-> lane_oe == '0)
        else $error("lanes driven outside frame");
    a_conv_ready_low: assert property ($rose(convert_start_select) |-> !ready_indicator [*8])
        else $error("ready rose too early after close");
    a_ready_returns: assert property ($rose(convert_start_select) |-> ##[8:40] ready_indicator)
        else $error("ready did not return after conversion");
    a_host_waits: assert property ($rose(convert_start_select) |-> convert_start_select [*8])
        else $error("new frame during conversion");
    a_sclk_idle: assert property (convert_start_select |-> !sclk)
        else $error("serial clock active outside frame");
    a_sdi_hold: assert property ($rose(sclk) |-> $stable(sdi))
        else $error("input bit changed at capture edge");
    a_lane_hold: assert property ($rose(sclk) && !convert_start_select |-> $stable(lane_o))
        else $error("output bit changed at capture edge");

    c_frame_closed: cover property ($rose(convert_start_select));
    c_ready_back: cover property ($rose(ready_indicator));
    c_capture: cover property ($rose(sclk) && !convert_start_select);
endmodule

/* File: testbench.sv */
// Self-checking bench joining host and device ends over the link
`timescale 1ns/10ps
module testbench;
    import sfcp_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic [31:0] req_cmd = 32'h0;
    logic [CNT_W-1:0] req_bits = 6'h00;
    logic busy, rsp_valid, conv_start, rd_pend = 1'b0;
    logic [31:0] rsp_data, last_cmd, rd_word, conv_word = 32'h0;
    logic [1:0] lane_en = 2'h1;
    logic [1:0] frame_kind;
    logic [7:0] user_addr = 8'h00;
    logic [7:0] user_rdata;
    logic [7:0] regs [256];
    logic [31:0] rnd = 32'hd60025d8;
    logic [31:0] cc [16];
    int nn [16];
    logic [4:0] ops [7];
    int fails = 0;
    int n_checks = 0;
    int n_frames = 0;
    int n_starts = 0;

    sfcp_link_if #(.LANES(2)) link ();
    sfcp_host #(.WAIT_CYCLES(40)) sfcp_host_i (.core_clk(core_clk), .rst(rst), .link(link),
        .req(req), .req_cmd(req_cmd), .req_bits(req_bits), .busy(busy),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    sfcp_dev #(.LANES(2), .CONV_CYCLES(8)) sfcp_dev_i (.core_clk(core_clk), .rst(rst),
        .link(link), .conv_word(conv_word), .lane_en(lane_en), .user_addr(user_addr),
        .user_rdata(user_rdata), .conv_start(conv_start), .frame_kind(frame_kind),
        .last_cmd(last_cmd));
    sfcp_asserts #(.LANES(2)) sfcp_asserts_i (.core_clk(core_clk), .rst(rst),
        .sclk(link.sclk), .convert_start_select(link.convert_start_select), .sdi(link.sdi),
        .lane_o(link.lane_o), .lane_oe(link.lane_oe), .ready_indicator(link.ready_indicator));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (rst === 1'b0 && conv_start === 1'b1) n_starts++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction

    function automatic logic [31:0] mk(input logic [4:0] op, input logic [1:0] sub,
                                       input logic [7:0] adr, input logic [15:0] d);
        return {op, sub, 1'b0, adr, d};
    endfunction

    // Reference effect of one frame on the byte array and the next read word
    function automatic bit model(input logic [31:0] c, input int n);
        logic [7:0] e;
        logic [7:0] o;
        e = {c[23:17], 1'b0};
        o = {c[23:17], 1'b1};
        rd_pend = 1'b0;
        if (n < 32 || c[24]) return 1'b0;
        case (c[31:27])
            OP_CLR: begin
                regs[e] &= ~c[7:0];
                regs[o] &= ~c[15:8];
            end
            OP_SET: begin
                regs[e] |= c[7:0];
                regs[o] |= c[15:8];
            end
            OP_WR: begin
                if (c[26:25] == SUB_BOTH || c[26:25] == SUB_LOW) regs[e] = c[7:0];
                if (c[26:25] == SUB_BOTH || c[26:25] == SUB_HIGH) regs[o] = c[15:8];
                return c[26:25] != 2'h3;
            end
            OP_RDH: begin
                rd_word = {regs[o], regs[e], 16'h0000};
                rd_pend = 1'b1;
            end
            OP_RDB: begin
                rd_word = {regs[c[23:16]], 24'h000000};
                rd_pend = 1'b1;
            end
            default: return 1'b0;
        endcase
        return 1'b1;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        n_checks++;
        if (seen !== expv) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, expv, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wait_on(input bit for_rsp);
        int t;
        t = 0;
        while ((for_rsp ? rsp_valid !== 1'b1 : busy !== 1'b0) && t < 4000) begin
            @(posedge core_clk);
            #1;
            t++;
        end
        if (t >= 4000) begin
            fails++;
            final_report();
        end
    endtask

    task automatic regs_check();
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            user_addr <= i[7:0];
            repeat (2) @(posedge core_clk);
            #1;
            check("register byte", {24'h0, user_rdata}, {24'h0, regs[i]});
        end
    endtask

    task automatic frame(input logic [31:0] c, input int n);
        logic [31:0] m;
        logic [31:0] w;
        bit ok;
        logic [1:0] k;
        rnd = lfsr(rnd);
        @(posedge core_clk);
        conv_word <= rnd;
        lane_en <= {rnd[7], 1'b1};
        w = rd_pend ? rd_word : rnd;
        req <= 1'b1;
        req_cmd <= c;
        req_bits <= n[CNT_W-1:0];
        @(posedge core_clk);
        req <= 1'b0;
        n_frames++;
        wait_on(1'b1);
        m = n < 32 ? (32'h1 << n) - 32'h1 : ~((32'h1 << (n - 32)) - 32'h1);
        w = n < 32 ? w >> (32 - n) : w << (n - 32);
        check("read word", rsp_data & m, w & m);
        ok = model(c, n);
        wait_on(1'b0);
        k = n < 32 ? FK_SHORT : n == 32 ? FK_OPT : FK_LONG;
        check("frame kind", {30'h0, frame_kind}, {30'h0, k});
        if (n < 32 || ok || c[24]) begin
            check("last command", last_cmd, (n < 32 || c[24]) ? CMD_NOP : c);
        end
        regs_check();
    endtask

    initial begin
        for (int i = 0; i < 256; i++) regs[i] = REG_RST;
        ops = '{OP_CLR, OP_RDH, OP_RDB, OP_WR, OP_SET, 5'h00, 5'h1f};
        cc = '{mk(OP_WR, SUB_BOTH, 8'h05, 16'h12a5), mk(OP_RDH, 2'h0, 8'h05, 16'h0),
            mk(OP_RDB, 2'h0, 8'h05, 16'h0), mk(OP_WR, SUB_HIGH, 8'h06, 16'h3c77),
            mk(OP_WR, SUB_LOW, 8'h07, 16'h3c77), mk(OP_WR, 2'h3, 8'h08, 16'hffff),
            mk(OP_SET, 2'h1, 8'h04, 16'hf00f), mk(OP_CLR, 2'h3, 8'h05, 16'h0181),
            CMD_NOP, mk(OP_WR, 2'h0, 8'h0a, 16'hbeef) | 32'h0100_0000,
            mk(OP_WR, 2'h0, 8'h0a, 16'hbeef), mk(OP_RDH, 2'h0, 8'h04, 16'h0),
            mk(OP_WR, 2'h0, 8'h0c, 16'h5a5a), mk(5'h1f, 2'h0, 8'h0c, 16'hffff),
            mk(OP_RDB, 2'h0, 8'h0d, 16'h0), mk(OP_RDH, 2'h0, 8'h06, 16'h0)};
        nn = '{32, 32, 32, 32, 32, 32, 32, 32, 32, 32, 31, 1, 40, 32, 63, 32};
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        regs_check();
        for (int i = 0; i < 16; i++) frame(cc[i], nn[i]);
        for (int i = 0; i < 30; i++) begin
            rnd = lfsr(rnd);
            frame(mk(ops[rnd[31:16] % 7], rnd[9:8], {4'h0, rnd[3:0]}, rnd[31:16])
                | {7'h0, &rnd[14:12], 24'h0},
                rnd[20:18] == 3'h0 ? 1 + rnd[4:0] : rnd[20:18] == 3'h1 ? 32 + rnd[4:0] : 32);
        end
        repeat (4) @(posedge core_clk);
        check("conversion starts", n_starts, n_frames);
        final_report();
    end
endmodule
